// ---- core/rwmc_top.sv ----
// Radio wake and modem configuration register bank with smart wake sequencer.
// Assumes one 100 MHz clock, synchronous active-low reset, an 8-bit register
// port with read data one cycle after the read strobe, and asynchronous
// wake timer and preamble detect inputs.
//
// Overview of operation
// [R01] Wake-count threshold high byte at 0x105, low byte at 0x104.
// [R02] Wake count above threshold enters radio off and flags wake-count interrupt.
// [R03] Smart wake: listen on stored channel for dwell, sleep if no preamble.
// [R04] Dwell tick is 128 times divider over 6.5 MHz; dwell is count ticks.
// [R05] Level threshold in dBm equals register value minus 107.
// [R06] 24-bit tuning word from three bytes, lowest first; frequency 26 MHz times word/65536.
// [R07] 12-bit rate code from 0x10C and low nibble of 0x10D; rate 100 bps steps.
// [R08] 12-bit deviation code from 0x10E and high nibble of 0x10D; 100 Hz steps.
// [R09] Byte at 0x10F sets correlator demodulator bandwidth.
// [R10] Post-detector filter width is twice the code; software keeps it 1 to 255.
// [R11] Software writes zero to loop adjust field unless table select is 1 or 3.
// [R12] Low two bits of 0x112 set correlator demodulator phase.
// [R13] Software writes zero to the spare configuration byte.
`timescale 1ns/100ps
module rwmc_top #(
  parameter int unsigned PRESCALE = rwmc_pkg::PRESCALE_CYC
) (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  // Register port
  input  wire rwmc_pkg::rwmc_bus_req_t  bus_req_i,
  output logic [7:0]                    bus_rdata_o,
  // Radio side events
  input  wire logic                     wake_timer_i,
  input  wire logic                     preamble_det_i,
  input  wire logic signed [7:0]        rssi_dbm_i,
  // Radio control
  output rwmc_pkg::rwmc_radio_cfg_t     radio_cfg_o,
  output logic [23:0]                   rx_tuning_word_o,
  output logic                          rx_enable_o,
  output logic                          sleep_o,
  output logic                          radio_off_o,
  // Interrupt
  output logic                          irq_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic is_cfg(input logic [9:0] a);
    is_cfg = (a >= rwmc_pkg::OFS_WAKE_THR_LOW) && (a <= rwmc_pkg::OFS_LOOP_PHASE);
  endfunction : is_cfg

  function automatic logic [3:0] cfg_idx(input logic [9:0] a);
    logic [9:0] d;
    d       = a - rwmc_pkg::OFS_WAKE_THR_LOW;
    cfg_idx = d[3:0];
  endfunction : cfg_idx

  localparam int unsigned N = rwmc_pkg::CFG_COUNT;

  logic [7:0]        cfg_mem_r [N];
  logic [7:0]        control_r;
  logic [3:0]        irq_status_r;
  logic [3:0]        irq_mask_r;
  logic [15:0]       wake_cnt_r;
  rwmc_pkg::rwmc_state_t state_r;
  logic [7:0]        rdata_r;
  logic              irq_r;

  logic              wr_cfg;
  logic              go_sleep;
  logic [3:0]        irq_set;
  logic [3:0]        irq_clr;

  // ----------------------------------------------------------------
  // Register strobes
  // ----------------------------------------------------------------
  assign wr_cfg   = bus_req_i.wr && is_cfg(bus_req_i.addr);
  assign go_sleep = bus_req_i.wr && (bus_req_i.addr == rwmc_pkg::OFS_CONTROL)
                    && bus_req_i.wdata[rwmc_pkg::CTL_GO_SLEEP_BIT];
  assign irq_clr  = (bus_req_i.rd && (bus_req_i.addr == rwmc_pkg::OFS_IRQ_STATUS)) ? 4'hF : 4'h0;

  // ----------------------------------------------------------------
  // Configuration bytes
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_cfg
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          cfg_mem_r[gi] <= rwmc_pkg::RST_CFG_BYTE;
        end else if (wr_cfg && (cfg_idx(bus_req_i.addr) == 4'(gi))) begin
          cfg_mem_r[gi] <= bus_req_i.wdata; // R01
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Named views of the bank
  // ----------------------------------------------------------------
  logic [15:0] wake_thr;
  logic [7:0]  listen_period;
  logic [7:0]  tick_div;
  logic [7:0]  level_thr;

  assign wake_thr      = {cfg_mem_r[1], cfg_mem_r[0]}; // R01
  assign listen_period = cfg_mem_r[2];
  assign tick_div      = cfg_mem_r[3];
  assign level_thr     = cfg_mem_r[4];

  // ----------------------------------------------------------------
  // Control and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      control_r <= rwmc_pkg::RST_CONTROL;
    end else if (bus_req_i.wr && (bus_req_i.addr == rwmc_pkg::OFS_CONTROL)) begin
      control_r <= {1'b0, bus_req_i.wdata[6:0]};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= rwmc_pkg::RST_IRQ_MASK;
    end else if (bus_req_i.wr && (bus_req_i.addr == rwmc_pkg::OFS_IRQ_MASK)) begin
      irq_mask_r <= bus_req_i.wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] wake_sync_r;
  logic [1:0] pre_sync_r;
  logic       wake_prev_r;
  logic       wake_edge;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wake_sync_r <= 2'h0;
      pre_sync_r  <= 2'h0;
      wake_prev_r <= 1'b0;
    end else begin
      wake_sync_r <= {wake_sync_r[0], wake_timer_i};
      pre_sync_r  <= {pre_sync_r[0], preamble_det_i};
      wake_prev_r <= wake_sync_r[1];
    end
  end

  assign wake_edge = wake_sync_r[1] && !wake_prev_r
                     && control_r[rwmc_pkg::CTL_WAKE_TIMER_BIT];

  // ----------------------------------------------------------------
  // Dwell tick divider
  // ----------------------------------------------------------------
  localparam int unsigned PS_W = $clog2(PRESCALE + 1);

  logic [PS_W-1:0] pre_cnt_r;
  logic [7:0]      div_cnt_r;
  logic [7:0]      dwell_cnt_r;
  logic            pre_pulse;
  logic            dwell_tick;
  logic            dwell_done;
  logic            listening;

  assign listening  = (state_r == rwmc_pkg::ST_LISTEN);
  assign pre_pulse  = listening && (pre_cnt_r == PS_W'(PRESCALE - 1));
  assign dwell_tick = pre_pulse && ((div_cnt_r + 8'h01) >= tick_div); // R04
  assign dwell_done = dwell_tick && ((dwell_cnt_r + 8'h01) >= listen_period); // R04

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !listening) begin
      pre_cnt_r <= '0;
    end else if (pre_pulse) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + PS_W'(1); // R04
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !listening) begin
      div_cnt_r <= 8'h00;
    end else if (dwell_tick) begin
      div_cnt_r <= 8'h00;
    end else if (pre_pulse) begin
      div_cnt_r <= div_cnt_r + 8'h01; // R04
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !listening) begin
      dwell_cnt_r <= 8'h00;
    end else if (dwell_tick) begin
      dwell_cnt_r <= dwell_cnt_r + 8'h01; // R04
    end
  end

  // ----------------------------------------------------------------
  // Signal level detection
  // ----------------------------------------------------------------
  logic signed [9:0] level_dbm;
  logic              level_hit;

  assign level_dbm = $signed({2'b00, level_thr}) - 10'(rwmc_pkg::LEVEL_OFFSET_DB); // R05
  assign level_hit = listening && control_r[rwmc_pkg::CTL_LEVEL_DET_BIT]
                     && ($signed({{2{rssi_dbm_i[7]}}, rssi_dbm_i}) > level_dbm); // R05

  // ----------------------------------------------------------------
  // Wake count
  // ----------------------------------------------------------------
  logic [15:0] wake_cnt_inc;
  logic        wake_over;

  assign wake_cnt_inc = wake_cnt_r + 16'h0001;
  assign wake_over    = wake_cnt_inc > wake_thr; // R02

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wake_cnt_r <= rwmc_pkg::RST_WAKE_CNT;
    end else if (wake_edge && (state_r == rwmc_pkg::ST_SLEEP)) begin
      wake_cnt_r <= wake_cnt_inc; // R02
    end else if (bus_req_i.wr && (bus_req_i.addr == rwmc_pkg::OFS_WAKE_CNT_LOW)) begin
      wake_cnt_r[7:0] <= bus_req_i.wdata;
    end else if (bus_req_i.wr && (bus_req_i.addr == rwmc_pkg::OFS_WAKE_CNT_HIGH)) begin
      wake_cnt_r[15:8] <= bus_req_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Smart wake sequencer
  // ----------------------------------------------------------------
  logic pre_seen;

  assign pre_seen = listening && pre_sync_r[1];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_r <= rwmc_pkg::ST_SLEEP;
    end else begin
      unique case (state_r)
        rwmc_pkg::ST_SLEEP: begin
          if (wake_edge && wake_over) begin
            state_r <= rwmc_pkg::ST_RADIO_OFF; // R02
          end else if (wake_edge && control_r[rwmc_pkg::CTL_SMART_WAKE_BIT]) begin
            state_r <= rwmc_pkg::ST_LISTEN; // R03
          end
        end
        rwmc_pkg::ST_LISTEN: begin
          if (go_sleep) begin
            state_r <= rwmc_pkg::ST_SLEEP;
          end else if (pre_seen || level_hit) begin
            state_r <= rwmc_pkg::ST_RECEIVE; // R03
          end else if (dwell_done) begin
            state_r <= rwmc_pkg::ST_SLEEP; // R03
          end
        end
        rwmc_pkg::ST_RECEIVE, rwmc_pkg::ST_RADIO_OFF: begin
          if (go_sleep) begin
            state_r <= rwmc_pkg::ST_SLEEP;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, read clears, set wins
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = 4'h0;
    irq_set[rwmc_pkg::IRQ_WAKE_COUNT_BIT] = wake_edge && wake_over
                                            && (state_r == rwmc_pkg::ST_SLEEP); // R02
    irq_set[rwmc_pkg::IRQ_PREAMBLE_BIT]   = pre_seen;
    irq_set[rwmc_pkg::IRQ_LEVEL_BIT]      = level_hit; // R05
    irq_set[rwmc_pkg::IRQ_DWELL_END_BIT]  = dwell_done && !pre_seen && !level_hit;
  end

  logic [3:0] irq_status_nxt;
  logic [3:0] irq_mask_nxt;

  assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;
  assign irq_mask_nxt   = (bus_req_i.wr && (bus_req_i.addr == rwmc_pkg::OFS_IRQ_MASK))
                          ? bus_req_i.wdata[3:0] : irq_mask_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_status_r <= 4'h0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_nxt & irq_mask_nxt); // R02
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
    end else if (bus_req_i.rd) begin
      if (is_cfg(bus_req_i.addr)) begin
        rdata_r <= cfg_mem_r[cfg_idx(bus_req_i.addr)];
      end else begin
        unique case (bus_req_i.addr)
          rwmc_pkg::OFS_CONTROL:       rdata_r <= control_r;
          rwmc_pkg::OFS_IRQ_STATUS:    rdata_r <= {4'h0, irq_status_r};
          rwmc_pkg::OFS_IRQ_MASK:      rdata_r <= {4'h0, irq_mask_r};
          rwmc_pkg::OFS_WAKE_CNT_LOW:  rdata_r <= wake_cnt_r[7:0];
          rwmc_pkg::OFS_WAKE_CNT_HIGH: rdata_r <= wake_cnt_r[15:8];
          rwmc_pkg::OFS_STATE:         rdata_r <= {6'h00, state_r};
          default:                     rdata_r <= 8'h00;
        endcase
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Radio outputs
  // ----------------------------------------------------------------
  rwmc_pkg::rwmc_radio_cfg_t cfg_r;
  logic                      rx_en_r;
  logic                      sleep_r;
  logic                      off_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_r <= '0;
    end else begin
      cfg_r.tuning_word                <= {cfg_mem_r[7], cfg_mem_r[6], cfg_mem_r[5]}; // R06
      cfg_r.bit_rate_code              <= {cfg_mem_r[9][rwmc_pkg::RATE_HI_LSB +: 4], cfg_mem_r[8]}; // R07
      cfg_r.tone_deviation_code        <= {cfg_mem_r[9][rwmc_pkg::DEV_HI_LSB +: 4], cfg_mem_r[10]}; // R08
      cfg_r.correlator_bandwidth       <= cfg_mem_r[11]; // R09
      cfg_r.post_detector_filter_width <= cfg_mem_r[12]; // R10
      cfg_r.correlator_phase           <= cfg_mem_r[14][rwmc_pkg::PHASE_LSB +: 2]; // R12
      cfg_r.rx_loop_bandwidth_adjust   <= cfg_mem_r[14][rwmc_pkg::LOOP_ADJ_LSB +: 6]; // R11
    end
  end

  // ----------------------------------------------------------------
  // State outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_en_r <= 1'b0;
      sleep_r <= 1'b1;
      off_r   <= 1'b0;
    end else begin
      rx_en_r <= (state_r == rwmc_pkg::ST_LISTEN) || (state_r == rwmc_pkg::ST_RECEIVE); // R03
      sleep_r <= (state_r == rwmc_pkg::ST_SLEEP);
      off_r   <= (state_r == rwmc_pkg::ST_RADIO_OFF); // R02
    end
  end

  assign bus_rdata_o      = rdata_r;
  assign radio_cfg_o      = cfg_r;
  assign rx_tuning_word_o = cfg_r.tuning_word;
  assign rx_enable_o      = rx_en_r;
  assign sleep_o          = sleep_r;
  assign radio_off_o      = off_r;
  assign irq_o            = irq_r;

endmodule : rwmc_top

// ---- common/rwmc_pkg.sv ----
// Package for the radio wake and modem configuration register bank.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package rwmc_pkg;

  // ----------------------------------------------------------------
  // Register port widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [9:0] OFS_WAKE_THR_LOW   = 10'h104;
  localparam logic [9:0] OFS_WAKE_THR_HIGH  = 10'h105;
  localparam logic [9:0] OFS_LISTEN_PERIOD  = 10'h106;
  localparam logic [9:0] OFS_TICK_DIVIDER   = 10'h107;
  localparam logic [9:0] OFS_LEVEL_THR      = 10'h108;
  localparam logic [9:0] OFS_TUNE_LOW       = 10'h109;
  localparam logic [9:0] OFS_TUNE_MID       = 10'h10A;
  localparam logic [9:0] OFS_TUNE_HIGH      = 10'h10B;
  localparam logic [9:0] OFS_RATE_LOW       = 10'h10C;
  localparam logic [9:0] OFS_RATE_DEV_HIGH  = 10'h10D;
  localparam logic [9:0] OFS_DEV_LOW        = 10'h10E;
  localparam logic [9:0] OFS_CORR_BW        = 10'h10F;
  localparam logic [9:0] OFS_POST_FILTER    = 10'h110;
  localparam logic [9:0] OFS_SPARE          = 10'h111;
  localparam logic [9:0] OFS_LOOP_PHASE     = 10'h112;
  localparam logic [9:0] OFS_CONTROL        = 10'h180;
  localparam logic [9:0] OFS_IRQ_STATUS     = 10'h181;
  localparam logic [9:0] OFS_IRQ_MASK       = 10'h182;
  localparam logic [9:0] OFS_WAKE_CNT_LOW   = 10'h183;
  localparam logic [9:0] OFS_WAKE_CNT_HIGH  = 10'h184;
  localparam logic [9:0] OFS_STATE          = 10'h185;
  localparam int unsigned CFG_FIRST         = 32'(OFS_WAKE_THR_LOW);
  localparam int unsigned CFG_COUNT         = 15;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_SMART_WAKE_BIT  = 0;
  localparam int unsigned CTL_LEVEL_DET_BIT   = 1;
  localparam int unsigned CTL_WAKE_TIMER_BIT  = 2;
  localparam int unsigned CTL_GO_SLEEP_BIT    = 7;
  localparam int unsigned IRQ_WAKE_COUNT_BIT  = 0;
  localparam int unsigned IRQ_PREAMBLE_BIT    = 1;
  localparam int unsigned IRQ_LEVEL_BIT       = 2;
  localparam int unsigned IRQ_DWELL_END_BIT   = 3;
  localparam int unsigned IRQ_W               = 4;
  localparam int unsigned RATE_HI_LSB         = 0;
  localparam int unsigned DEV_HI_LSB          = 4;
  localparam int unsigned PHASE_LSB           = 0;
  localparam int unsigned LOOP_ADJ_LSB        = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CFG_BYTE  = 8'h00;
  localparam logic [7:0]  RST_CONTROL   = 8'h00;
  localparam logic [3:0]  RST_IRQ_MASK  = 4'h0;
  localparam logic [15:0] RST_WAKE_CNT  = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_REF_HZ     = 6_500_000;
  localparam int unsigned TICK_REF_MULT   = 128;
  localparam int unsigned PRESCALE_CYC    = (TICK_REF_MULT * (CLK_HZ / 100)) / (TICK_REF_HZ / 100);
  localparam int signed   LEVEL_OFFSET_DB = 107;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SLEEP     = 2'b00,
    ST_LISTEN    = 2'b01,
    ST_RECEIVE   = 2'b11,
    ST_RADIO_OFF = 2'b10
  } rwmc_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rwmc_bus_req_t;

  typedef struct packed {
    logic [23:0] tuning_word;
    logic [11:0] bit_rate_code;
    logic [11:0] tone_deviation_code;
    logic [7:0]  correlator_bandwidth;
    logic [7:0]  post_detector_filter_width;
    logic [1:0]  correlator_phase;
    logic [5:0]  rx_loop_bandwidth_adjust;
  } rwmc_radio_cfg_t;

endpackage : rwmc_pkg

// ---- verif/rwmc_properties.sv ----
// Concurrent checks for the radio wake and modem configuration bank.
// Assumes binding to rwmc_top; sees only its ports.
`timescale 1ns/100ps
module rwmc_properties (
  // Clock and reset
  input wire logic                      clk_sys_i,
  input wire logic                      rst_n_i,
  // Register port
  input wire rwmc_pkg::rwmc_bus_req_t   bus_req_i,
  input wire logic [7:0]                bus_rdata_o,
  // Radio control
  input wire rwmc_pkg::rwmc_radio_cfg_t radio_cfg_o,
  input wire logic                      rx_enable_o,
  input wire logic                      sleep_o,
  input wire logic                      radio_off_o
);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wr(logic [9:0] a);
    bus_req_i.wr && bus_req_i.addr == a;
  endsequence

  sequence s_rd(logic [9:0] a);
    bus_req_i.rd && bus_req_i.addr == a;
  endsequence

  property p_byte(logic [9:0] a, logic [7:0] f);
    s_wr(a) |-> ##2 f == $past(bus_req_i.wdata, 2);
  endproperty

  a_rate_low: assert property (p_byte(10'h10C, radio_cfg_o.bit_rate_code[7:0]))
    else $error("rate code low byte not applied");
  a_dev_low: assert property (p_byte(10'h10E, radio_cfg_o.tone_deviation_code[7:0]))
    else $error("deviation code low byte not applied");
  a_tune_low: assert property (p_byte(10'h109, radio_cfg_o.tuning_word[7:0]))
    else $error("tuning word low byte not applied");
  a_tune_high: assert property (p_byte(10'h10B, radio_cfg_o.tuning_word[23:16]))
    else $error("tuning word high byte not applied");
  a_corr_bw: assert property (p_byte(10'h10F, radio_cfg_o.correlator_bandwidth))
    else $error("correlator bandwidth not applied");
  a_post_filter: assert property (p_byte(10'h110, radio_cfg_o.post_detector_filter_width))
    else $error("post filter width not applied");
  a_shared_nibbles: assert property (s_wr(10'h10D) |-> ##2 {radio_cfg_o.tone_deviation_code[11:8],
    radio_cfg_o.bit_rate_code[11:8]} == $past(bus_req_i.wdata, 2))
    else $error("shared nibble register split wrong");
  a_phase_split: assert property (s_wr(10'h112) |-> ##2 {radio_cfg_o.rx_loop_bandwidth_adjust,
    radio_cfg_o.correlator_phase} == $past(bus_req_i.wdata, 2))
    else $error("phase register split wrong");
  a_rdata_idle: assert property (!$past(bus_req_i.rd) |-> bus_rdata_o == 8'h00)
    else $error("read data outside read answer");
  a_unmapped_zero: assert property (s_rd(10'h3FF) |=> bus_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_one_state: assert property ($onehot({rx_enable_o, sleep_o, radio_off_o}))
    else $error("state outputs not one-hot");
  a_listen_entry: assert property ($rose(rx_enable_o) |-> $past(sleep_o))
    else $error("listen entered from other than sleep");
  a_off_entry: assert property ($rose(radio_off_o) |-> $past(sleep_o))
    else $error("radio off entered from other than sleep");
endmodule : rwmc_properties

bind rwmc_top rwmc_properties i_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i),
  .bus_rdata_o(bus_rdata_o), .radio_cfg_o(radio_cfg_o), .rx_enable_o(rx_enable_o), .sleep_o(sleep_o),
  .radio_off_o(radio_off_o));

// ---- verif/tb_top.sv ----
// Self-checking bench for the radio wake and modem configuration bank.
// Assumes rwmc_pkg and rwmc_top compiled first; short prescale of 4.
`timescale 1ns/100ps
module tb_top;
  logic                      clk_sys_i;
  logic                      rst_n_i;
  rwmc_pkg::rwmc_bus_req_t   req;
  logic [7:0]                rdata;
  logic                      wake;
  logic                      pre;
  logic [7:0]                rssi;
  rwmc_pkg::rwmc_radio_cfg_t cfg;
  logic [23:0]               rx_tw;
  logic                      rx_en;
  logic                      slp;
  logic                      off;
  logic                      irq;
  logic                      rd_seen;
  logic [7:0]                exp_q[$];
  logic [7:0]                c[15];
  int                        n;
  int                        n_mismatch;
  int                        comparisons;

  rwmc_top #(.PRESCALE(4)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_req_i(req),
    .bus_rdata_o(rdata), .wake_timer_i(wake), .preamble_det_i(pre), .rssi_dbm_i(rssi), .radio_cfg_o(cfg),
    .rx_tuning_word_o(rx_tw), .rx_enable_o(rx_en), .sleep_o(slp), .radio_off_o(off), .irq_o(irq));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_sys_i);
    req <= '0;
  endtask : bus

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic wait_on(input int sel, input int lim);
    n = 0;
    while (!((sel == 0 && rx_en === 1'b1) || (sel == 1 && slp === 1'b1) || (sel == 2 && off === 1'b1))) begin
      @(negedge clk_sys_i);
      n++;
      if (n > lim) begin
        n_mismatch++;
        close_out();
      end
    end
  endtask : wait_on

  task automatic kick();
    @(posedge clk_sys_i);
    wake <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    wake <= 1'b0;
  endtask : kick

  // Read answers checked in the cycle after the strobe
  always @(posedge clk_sys_i) rd_seen <= req.rd;
  always @(negedge clk_sys_i) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0);
      else chk(rdata, exp_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    wake = 1'b0;
    pre = 1'b0;
    rssi = 8'h00;
    rd_seen = 1'b0;
    rst_n_i = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(32'h3563627E));
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(cfg, 0);
    chk({rx_en, slp, off, irq}, 4'b0100);
    for (int i = 0; i < 15; i++) rd(10'(rwmc_pkg::CFG_FIRST + i), 8'h00);
    $display("test reset done");
    for (int i = 0; i < 15; i++) c[i] = 8'($urandom());
    c[12] = (c[12] == 8'h00) ? 8'h01 : c[12];
    c[13] = 8'h00;
    c[14] = c[14] & 8'h03;
    for (int i = 0; i < 15; i++) bus(1'b1, 10'(rwmc_pkg::CFG_FIRST + i), c[i]);
    for (int i = 0; i < 15; i++) rd(10'(rwmc_pkg::CFG_FIRST + i), c[i]);
    @(negedge clk_sys_i);
    chk(cfg.tuning_word, {c[7], c[6], c[5]});
    chk(cfg.bit_rate_code, {c[9][3:0], c[8]});
    chk(cfg.tone_deviation_code, {c[9][7:4], c[10]});
    chk(cfg.correlator_bandwidth, c[11]);
    chk(cfg.post_detector_filter_width, c[12]);
    chk({cfg.rx_loop_bandwidth_adjust, cfg.correlator_phase}, c[14]);
    bus(1'b1, 10'h3FF, 8'hA5);
    rd(10'h3FF, 8'h00);
    $display("test config done");
    bus(1'b1, rwmc_pkg::OFS_WAKE_THR_LOW, 8'h00);
    bus(1'b1, rwmc_pkg::OFS_WAKE_THR_HIGH, 8'h01);
    bus(1'b1, rwmc_pkg::OFS_TICK_DIVIDER, 8'h01);
    bus(1'b1, rwmc_pkg::OFS_LISTEN_PERIOD, 8'h05);
    bus(1'b1, rwmc_pkg::OFS_IRQ_MASK, 8'h0F);
    bus(1'b1, rwmc_pkg::OFS_CONTROL, 8'h05);
    kick();
    wait_on(0, 20);
    chk(rx_tw, {c[7], c[6], c[5]});
    wait_on(1, 40);
    chk(n >= 15 && n <= 24, 1);
    chk(irq, 1);
    rd(rwmc_pkg::OFS_IRQ_STATUS, 8'h08);
    repeat (2) @(negedge clk_sys_i);
    chk(irq, 0);
    rd(rwmc_pkg::OFS_WAKE_CNT_LOW, 8'h01);
    $display("test listen done");
    bus(1'b1, rwmc_pkg::OFS_IRQ_MASK, 8'h00);
    kick();
    wait_on(0, 20);
    @(posedge clk_sys_i);
    pre <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rd(rwmc_pkg::OFS_STATE, 8'h03);
    chk(irq, 0);
    rd(rwmc_pkg::OFS_IRQ_STATUS, 8'h02);
    pre <= 1'b0;
    bus(1'b1, rwmc_pkg::OFS_CONTROL, 8'h85);
    wait_on(1, 10);
    rd(rwmc_pkg::OFS_CONTROL, 8'h05);
    $display("test preamble done");
    bus(1'b1, rwmc_pkg::OFS_IRQ_MASK, 8'h0F);
    bus(1'b1, rwmc_pkg::OFS_LEVEL_THR, 8'h50);
    bus(1'b1, rwmc_pkg::OFS_CONTROL, 8'h07);
    rssi <= 8'hE5;
    kick();
    wait_on(0, 20);
    repeat (4) @(posedge clk_sys_i);
    rd(rwmc_pkg::OFS_STATE, 8'h01);
    rssi <= 8'hE6;
    repeat (3) @(posedge clk_sys_i);
    rd(rwmc_pkg::OFS_STATE, 8'h03);
    rd(rwmc_pkg::OFS_IRQ_STATUS, 8'h04);
    bus(1'b1, rwmc_pkg::OFS_CONTROL, 8'h85);
    wait_on(1, 10);
    $display("test level done");
    bus(1'b1, rwmc_pkg::OFS_WAKE_THR_HIGH, 8'h00);
    bus(1'b1, rwmc_pkg::OFS_WAKE_THR_LOW, 8'h04);
    kick();
    wait_on(0, 20);
    wait_on(1, 40);
    rd(rwmc_pkg::OFS_IRQ_STATUS, 8'h08);
    kick();
    wait_on(2, 20);
    rd(rwmc_pkg::OFS_IRQ_STATUS, 8'h01);
    rd(rwmc_pkg::OFS_STATE, 8'h02);
    kick();
    rd(rwmc_pkg::OFS_WAKE_CNT_LOW, 8'h05);
    bus(1'b1, rwmc_pkg::OFS_WAKE_CNT_HIGH, 8'h3C);
    bus(1'b1, rwmc_pkg::OFS_WAKE_CNT_LOW, 8'hA5);
    rd(rwmc_pkg::OFS_WAKE_CNT_HIGH, 8'h3C);
    rd(rwmc_pkg::OFS_WAKE_CNT_LOW, 8'hA5);
    rd(rwmc_pkg::OFS_IRQ_MASK, 8'h0F);
    bus(1'b1, rwmc_pkg::OFS_CONTROL, 8'h85);
    wait_on(1, 10);
    $display("test threshold done");
    close_out();
  end
endmodule : tb_top
